/* File: core/lockstep_pkg.sv */
// Shared constants, register map and carrier types for the lockstep
// self-test block.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
package lockstep_pkg;

   // ********************************************************************
   // Clock and timing figures
   // ********************************************************************
   localparam int CLOCK_MHZ = 100; // CPU clock rate in MHz.
   localparam int SELF_TEST_MAX_MHZ = 45; // Highest self-test clock rate in MHz.
   // Smallest division that keeps the self-test clock at or below its limit.
   localparam logic [3:0] SELF_TEST_MIN_DIV =
      4'((CLOCK_MHZ + SELF_TEST_MAX_MHZ - 1) / SELF_TEST_MAX_MHZ);
   localparam logic [3:0] SELF_TEST_DIV_ONE = 4'h1; // Divide field zero gives ratio one before the SELF_TEST_MIN_DIV minimum applies.
   localparam logic [10:0] INTERVAL_TICKS = 11'h555; // Self-test clocks per interval (1365).
   localparam logic [4:0] INTERVAL_TOTAL = 5'h1A; // Number of test intervals (26).
   localparam logic [3:0] RESET_HOLD = 4'h8; // CPU reset length in clock cycles.
   localparam logic [31:0] TIMEOUT_RESET = 32'h000F_FFFF; // Default timeout period.

   // ********************************************************************
   // Register byte addresses
   // ********************************************************************
   localparam logic [31:0] ADDR_CONTROL = 32'h0FFF_E100; // Start strobe.
   localparam logic [31:0] ADDR_CONFIG = 32'h0FFF_E104; // Interval count, restart.
   localparam logic [31:0] ADDR_CLOCK_DIVIDER = 32'h0FFF_E108; // Self-test clock divider.
   localparam logic [31:0] ADDR_TIMEOUT = 32'h0FFF_E10C; // Timeout period in cycles.
   localparam logic [31:0] ADDR_RUN_STATUS = 32'h0FFF_E110; // Run status, read only.
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0FFF_E114; // Sticky events, write 1 clears.
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h0FFF_E118; // Interrupt enables.
   localparam logic [31:0] ADDR_EXCEPTION = 32'h0FFF_E11C; // Reset causes, write 1 clears.

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int CTRL_START_BIT = 0; // Control: start a run.
   localparam int CFG_COUNT_LSB = 0; // Config: intervals per run, zero means all remaining.
   localparam int CFG_RESTART_BIT = 8; // Config: restart at the first interval.
   localparam int DIV_FIELD_LSB = 0; // Divider: divide field, ratio is field plus one, but never below SELF_TEST_MIN_DIV.
   localparam int RUN_BUSY_BIT = 0; // Run status: run in progress.
   localparam int RUN_FAIL_BIT = 1; // Run status: an interval failed.
   localparam int RUN_TIMEOUT_BIT = 2; // Run status: the run timed out.
   localparam int RUN_FAIL_LSB = 8; // Run status: failing interval number.
   localparam int RUN_NEXT_LSB = 16; // Run status: interval the next run resumes at.
   localparam int IRQ_DONE = 0; // Event: run finished.
   localparam int IRQ_FAIL = 1; // Event: interval failed.
   localparam int IRQ_TIMEOUT = 2; // Event: run timed out.
   localparam int IRQ_COMPARE = 3; // Event: core outputs mismatched.
   localparam int EXC_EXTERNAL = 3; // Reset cause: external reset.
   localparam int EXC_SOFTWARE = 4; // Reset cause: software reset.
   localparam int EXC_SELF_TEST = 5; // Reset cause: self-test controller.
   localparam int EXC_WATCHDOG = 13; // Reset cause: watchdog or debugger.

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {run_idle, run_active, run_reset} run_state_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_request_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_answer_type;

   typedef struct packed {
      logic run; // Engine active.
      logic step; // One self-test clock enable.
      logic [4:0] interval; // Interval being executed.
   } builtin_test_type;

endpackage : lockstep_pkg

/* File: core/cpu_lockstep_self_test.sv */
// Lockstep compare unit and self-test controller for two processor cores.
// Assumes the cores, the test engine and the reset-cause sources run on
// the same clock; only software reaches the registers, over APB.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns

module cpu_lockstep_self_test (
   input wire logic clock, // CPU clock, 100 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire lockstep_pkg::apb_request_type apb_in, // APB request from the master.
   output lockstep_pkg::apb_answer_type apb_out, // APB answer to the master.
   input wire logic [31:0] system_in, // Data from the system to the cores.
   output logic [31:0] core_a_in, // Data into the first core.
   output logic [31:0] core_b_in, // Data into the second core, two cycles later.
   input wire logic [31:0] core_a_out, // Outputs of the first core.
   input wire logic [31:0] core_b_out, // Outputs of the second core.
   output logic [31:0] system_out, // Core outputs passed to the system.
   output logic core_clock_enable, // Common clock enable of both cores.
   output logic core_isolate, // Cores cut off from the system.
   output lockstep_pkg::builtin_test_type test_engine, // Commands to the test engine.
   input wire logic test_pass, // Engine signature good at interval end.
   input wire logic software_reset_event, // Software reset request seen.
   input wire logic external_reset_event, // External reset seen.
   input wire logic watchdog_reset_event, // Watchdog or debugger reset seen.
   output logic cpu_reset, // CPU reset issued at the end of a run.
   output logic compare_error, // Lockstep mismatch pending.
   output logic irq // Level interrupt, high while an unmasked event is set.
);
   import lockstep_pkg::*;

   // ********************************************************************
   // State of the block
   // ********************************************************************
   typedef struct packed {
      run_state_type mode; // Controller state.
      logic [2:0] div_field; // Divide field of the self-test clock divider.
      logic [4:0] run_count; // Intervals per run, zero for all remaining.
      logic restart; // Start every run at the first interval.
      logic [31:0] timeout_period; // Timeout limit in CPU clock cycles.
      logic [3:0] div_count; // Position inside one self-test clock period.
      logic self_test_tick; // One self-test clock enable.
      logic core_enable; // Registered core clock enable.
      logic [10:0] tick_count; // Self-test clocks spent in this interval.
      logic [4:0] interval; // Interval being executed.
      logic [4:0] next_interval; // Interval the next run resumes at.
      logic [4:0] run_left; // Intervals still to execute in this run.
      logic [31:0] timeout_count; // Cycles spent in this run.
      logic [4:0] fail_interval; // Last failing interval.
      logic fail_flag; // An interval failed in the last run.
      logic timeout_flag; // The last run timed out.
      logic [3:0] irq_status; // Sticky events.
      logic [3:0] irq_mask; // Interrupt enables.
      logic [15:0] exception; // Sticky reset causes.
      logic [3:0] reset_count; // Cycles of CPU reset still to drive.
      logic [1:0][31:0] a_pipe; // Delay line of first-core outputs.
      logic [1:0] primed; // Compare delay line refilled since reset; blocks false errors.
      logic [31:0] a_in; // Registered input of the first core.
      logic [1:0][31:0] b_in_pipe; // Delay line of second-core inputs.
      logic [31:0] sys_out; // Registered outputs to the system.
      logic ack; // APB ready, one wait state.
      logic [31:0] prdata; // Registered read data.
      logic pslverr; // Registered error answer.
   } block_state_type;

   block_state_type cur; // Present state.
   block_state_type next_cur; // State for the next edge.
   logic access; // APB access phase in progress.
   logic write_now; // Write takes effect at this edge.
   logic hit; // Address is a mapped register.
   logic [31:0] read_word; // Register selected for reading.
   logic [3:0] irq_set; // Events raised this cycle.
   logic [3:0] irq_clear; // Events cleared by software this cycle.
   logic [15:0] exc_set; // Reset causes raised this cycle.
   logic [15:0] exc_clear; // Reset causes cleared by software.
   logic [4:0] start_at; // First interval of a starting run.
   logic mismatch; // Delayed outputs differ.
   logic interval_end; // Last self-test clock of an interval.

   // ********************************************************************
   // Helpers
   // ********************************************************************

   // Sticky bit update: a new event wins over a clear in the same cycle.
   function automatic logic [15:0] sticky(input logic [15:0] old, input logic [15:0] set,
                                          input logic [15:0] clr);
      sticky = set | (old & ~clr);
   endfunction : sticky

   // Effective self-test clock division, never faster than the limit.
   function automatic logic [3:0] divide_ratio(input logic [2:0] field);
      logic [3:0] ratio;
      ratio = {1'b0, field} + SELF_TEST_DIV_ONE;
      if (ratio < SELF_TEST_MIN_DIV) begin
         ratio = SELF_TEST_MIN_DIV;
      end
      divide_ratio = ratio;
   endfunction : divide_ratio

   // Address decode shared by reads and the error answer.
   function automatic logic mapped(input logic [31:0] addr);
      mapped = (addr == ADDR_CONTROL) || (addr == ADDR_CONFIG) ||
               (addr == ADDR_CLOCK_DIVIDER) || (addr == ADDR_TIMEOUT) ||
               (addr == ADDR_RUN_STATUS) || (addr == ADDR_IRQ_STATUS) ||
               (addr == ADDR_IRQ_MASK) || (addr == ADDR_EXCEPTION);
   endfunction : mapped

   // ********************************************************************
   // Register read mux
   // ********************************************************************

   // Assemble the word that a read at the current address returns.
   always_comb begin
      read_word = '0;
      hit = mapped(apb_in.paddr);
      case (apb_in.paddr)
         ADDR_CONFIG: begin
            read_word[CFG_COUNT_LSB +: 5] = cur.run_count;
            read_word[CFG_RESTART_BIT] = cur.restart;
         end
         ADDR_CLOCK_DIVIDER: begin
            read_word[DIV_FIELD_LSB +: 3] = cur.div_field;
         end
         ADDR_TIMEOUT: begin
            read_word = cur.timeout_period;
         end
         ADDR_RUN_STATUS: begin
            read_word[RUN_BUSY_BIT] = (cur.mode != run_idle);
            read_word[RUN_FAIL_BIT] = cur.fail_flag;
            read_word[RUN_TIMEOUT_BIT] = cur.timeout_flag;
            read_word[RUN_FAIL_LSB +: 5] = cur.fail_interval;
            read_word[RUN_NEXT_LSB +: 5] = cur.next_interval;
         end
         ADDR_IRQ_STATUS: begin
            read_word[3:0] = cur.irq_status;
         end
         ADDR_IRQ_MASK: begin
            read_word[3:0] = cur.irq_mask;
         end
         ADDR_EXCEPTION: begin
            read_word[15:0] = cur.exception;
         end
         default: begin
            // The control register and unmapped words read as zero.
         end
      endcase
   end

   // ********************************************************************
   // Next-state logic
   // ********************************************************************

   // All behaviour of the block is worked out here from the present state.
   always_comb begin
      next_cur = cur;
      irq_set = '0;
      irq_clear = '0;
      exc_set = '0;
      exc_clear = '0;
      access = apb_in.psel & apb_in.penable;
      write_now = access & cur.ack & apb_in.pwrite;
      start_at = cur.restart ? 5'h00 : cur.next_interval;
      interval_end = cur.self_test_tick && (cur.tick_count == INTERVAL_TICKS - 11'h001);

      // Bus answer: one wait state, so read data and error come from flops.
      next_cur.ack = access & ~cur.ack;
      if (access && !cur.ack) begin
         next_cur.prdata = apb_in.pwrite ? 32'h0000_0000 : read_word;
         next_cur.pslverr = ~hit;
      end

      // Register writes, taken at the edge where pready is high.
      if (write_now) begin
         case (apb_in.paddr)
            ADDR_CONFIG: begin
               next_cur.run_count = apb_in.pwdata[CFG_COUNT_LSB +: 5];
               next_cur.restart = apb_in.pwdata[CFG_RESTART_BIT];
            end
            ADDR_CLOCK_DIVIDER: begin
               next_cur.div_field = apb_in.pwdata[DIV_FIELD_LSB +: 3];
            end
            ADDR_TIMEOUT: begin
               next_cur.timeout_period = apb_in.pwdata;
            end
            ADDR_IRQ_STATUS: begin
               irq_clear = apb_in.pwdata[3:0];
            end
            ADDR_IRQ_MASK: begin
               next_cur.irq_mask = apb_in.pwdata[3:0];
            end
            ADDR_EXCEPTION: begin
               exc_clear = apb_in.pwdata[15:0];
            end
            default: begin
               // Control is handled below; other words ignore writes.
            end
         endcase
      end

      next_cur.a_pipe[0] = core_a_out;
      next_cur.a_pipe[1] = cur.a_pipe[0];
      next_cur.primed = {cur.primed[0], 1'b1};
      mismatch = (cur.a_pipe[1] != core_b_out) && (cur.mode == run_idle) && cur.primed[1];
      irq_set[IRQ_COMPARE] = mismatch;

      // isolate cores under test; inputs and outputs are held at zero.
      next_cur.a_in = (cur.mode == run_idle) ? system_in : 32'h0000_0000;
      next_cur.b_in_pipe[0] = cur.a_in;
      next_cur.b_in_pipe[1] = cur.b_in_pipe[0];
      next_cur.sys_out = (cur.mode == run_idle) ? cur.a_pipe[1] : 32'h0000_0000;

      // Reset causes from the rest of the system.
      exc_set[EXC_EXTERNAL] = external_reset_event;
      exc_set[EXC_SOFTWARE] = software_reset_event;
      exc_set[EXC_WATCHDOG] = watchdog_reset_event;

      // Self-test clock: both cores see one enable, full rate when idle.
      next_cur.self_test_tick = 1'b0;
      next_cur.core_enable = 1'b1;
      if (cur.mode == run_active) begin
         if (cur.div_count >= divide_ratio(cur.div_field) - 4'h1) begin
            next_cur.div_count = 4'h0;
            next_cur.self_test_tick = 1'b1;
         end else begin
            next_cur.div_count = cur.div_count + 4'h1;
         end
         next_cur.core_enable = next_cur.self_test_tick;
      end

      // Controller sequence.
      case (cur.mode)
         run_idle: begin
            // A start written during a run is ignored.
            if (write_now && (apb_in.paddr == ADDR_CONTROL) &&
                apb_in.pwdata[CTRL_START_BIT]) begin
               next_cur.mode = run_active;
               next_cur.interval = start_at;
               if ((cur.run_count == 5'h00) || (cur.run_count > INTERVAL_TOTAL - start_at)) begin
                  next_cur.run_left = INTERVAL_TOTAL - start_at;
               end else begin
                  next_cur.run_left = cur.run_count;
               end
               next_cur.fail_flag = 1'b0;
               next_cur.timeout_flag = 1'b0;
               next_cur.div_count = 4'h0;
               next_cur.tick_count = 11'h000;
               next_cur.timeout_count = 32'h0000_0000;
            end
         end
         run_active: begin
            next_cur.timeout_count = cur.timeout_count + 32'h0000_0001;
            if (cur.self_test_tick) begin
               next_cur.tick_count = interval_end ? 11'h000 : cur.tick_count + 11'h001;
            end
            if (interval_end) begin
               if (!test_pass) begin
                  next_cur.fail_flag = 1'b1;
                  next_cur.fail_interval = cur.interval;
                  irq_set[IRQ_FAIL] = 1'b1;
                  next_cur.mode = run_reset;
               end else begin
                  next_cur.run_left = cur.run_left - 5'h01;
                  next_cur.interval = cur.interval + 5'h01;
                  if (cur.interval + 5'h01 >= INTERVAL_TOTAL) begin
                     next_cur.next_interval = 5'h00;
                  end else begin
                     next_cur.next_interval = cur.interval + 5'h01;
                  end
                  if (cur.run_left == 5'h01) begin
                     next_cur.mode = run_reset;
                  end
               end
            end else if (cur.timeout_count >= cur.timeout_period) begin
               next_cur.timeout_flag = 1'b1;
               irq_set[IRQ_TIMEOUT] = 1'b1;
               next_cur.mode = run_reset;
            end
            next_cur.reset_count = RESET_HOLD;
         end
         run_reset: begin
            if (cur.reset_count == 4'h1) begin
               next_cur.mode = run_idle;
               irq_set[IRQ_DONE] = 1'b1;
               exc_set[EXC_SELF_TEST] = 1'b1;
            end
            next_cur.reset_count = cur.reset_count - 4'h1;
         end
         default: begin
            next_cur.mode = run_idle;
         end
      endcase

      // Sticky flags, with events winning over a clear in the same cycle.
      next_cur.irq_status = 4'(sticky({12'h000, cur.irq_status}, {12'h000, irq_set},
                                      {12'h000, irq_clear}));
      next_cur.exception = sticky(cur.exception, exc_set, exc_clear);
   end

   // ********************************************************************
   // State register
   // ********************************************************************

   // Every flop of the block; only constants are loaded under reset.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur <= '0;
         cur.mode <= run_idle;
         cur.timeout_period <= TIMEOUT_RESET;
         cur.core_enable <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign apb_out.prdata = cur.prdata;
   assign apb_out.pready = cur.ack;
   assign apb_out.pslverr = cur.pslverr & cur.ack;
   assign core_a_in = cur.a_in;
   assign core_b_in = cur.b_in_pipe[1];
   assign system_out = cur.sys_out;
   assign core_clock_enable = cur.core_enable;
   assign core_isolate = (cur.mode != run_idle);
   assign test_engine.run = (cur.mode == run_active);
   assign test_engine.step = cur.self_test_tick;
   assign test_engine.interval = cur.interval;
   assign cpu_reset = (cur.mode == run_reset);
   assign compare_error = cur.irq_status[IRQ_COMPARE];
   assign irq = |(cur.irq_status & cur.irq_mask);

endmodule : cpu_lockstep_self_test

/* File: verif/lockstep_properties.sv */
// Port checker of the lockstep self-test block.
// Assumes it is bound to the block's top module.
`timescale 1ns/1ns
module lockstep_properties (
   input wire logic clock, // CPU clock.
   input wire logic rst, // Reset, active high.
   input wire lockstep_pkg::apb_request_type apb_in, // Bus request.
   input wire lockstep_pkg::apb_answer_type apb_out, // Bus answer.
   input wire logic [31:0] core_a_in, // First core input.
   input wire logic [31:0] core_b_in, // Second core input.
   input wire logic [31:0] core_a_out, // First core output.
   input wire logic [31:0] core_b_out, // Second core output.
   input wire logic [31:0] system_out, // Output to the system.
   input wire logic core_isolate, // Cores cut off.
   input wire logic core_clock_enable, // Common core clock enable.
   input wire lockstep_pkg::builtin_test_type test_engine, // Engine commands.
   input wire logic cpu_reset, // CPU reset.
   input wire logic compare_error // Mismatch pending.
);
   import lockstep_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_skew_two: assert property (core_b_in == $past(core_a_in, 2))
      else $error("second core input not two cycles behind");
   a_compare_seen: assert property (!core_isolate && !$past(core_isolate)
      && core_b_out != $past(core_a_out, 2) |-> ##[1:3] compare_error)
      else $error("mismatch not flagged");
   a_error_sticky: assert property ($fell(compare_error) |-> $past(apb_out.pready
      && apb_in.pwrite && apb_in.paddr == ADDR_IRQ_STATUS && apb_in.pwdata[3]))
      else $error("compare flag dropped without a clear");
   a_isolate_quiet: assert property (core_isolate && $past(core_isolate)
      |-> system_out == 32'h0 && core_a_in == 32'h0) else $error("isolated core leaks");
   a_enable_step: assert property (test_engine.run && $past(test_engine.run)
      |-> core_clock_enable == test_engine.step) else $error("core enable not on step");
   a_run_isolated: assert property (test_engine.run |-> core_isolate)
      else $error("run without isolation");
   a_step_spacing: assert property (test_engine.step |=> (!test_engine.step)[*2])
      else $error("self-test clock too fast");
   a_reset_length: assert property ($rose(cpu_reset) |-> cpu_reset[*8] ##1 !cpu_reset)
      else $error("cpu reset length wrong");
   a_reset_stops: assert property (cpu_reset |-> core_isolate && !test_engine.run)
      else $error("engine still running in cpu reset");
   a_one_wait: assert property (apb_in.psel && apb_in.penable && !$past(apb_in.penable)
      |-> !apb_out.pready ##1 apb_out.pready) else $error("ready not in second access");
endmodule : lockstep_properties
bind cpu_lockstep_self_test lockstep_properties lockstep_properties_inst (.clock, .rst,
   .apb_in, .apb_out, .core_a_in, .core_b_in, .core_a_out, .core_b_out, .system_out,
   .core_isolate, .core_clock_enable, .test_engine, .cpu_reset, .compare_error);

/* File: verif/core_pair_model.sv */
// Behavioural model of the two lockstep cores and the test engine verdict.
// Assumes the block delays the second core's input by two cycles.
`timescale 1ns/1ns
module core_pair_model (
   input wire logic clock, // CPU clock.
   input wire logic [31:0] core_a_in, // First core input.
   input wire logic [31:0] core_b_in, // Second core input.
   input wire logic flip, // Corrupts the second core for one cycle.
   input wire logic pass, // Verdict the engine reports.
   output logic [31:0] core_a_out, // First core output.
   output logic [31:0] core_b_out, // Second core output.
   output logic test_pass // Engine signature good.
);
   // state fully defined
   // Both cores compute the same function, so outputs agree unless flip says otherwise.
   always_ff @(posedge clock) begin
      core_a_out <= {core_a_in[30:0], core_a_in[31]} ^ 32'h5A5A_A5A5;
      core_b_out <= {core_b_in[30:0], core_b_in[31]} ^ 32'h5A5A_A5A5 ^ {31'h0, flip};
   end
   assign test_pass = pass;
endmodule : core_pair_model

/* File: verif/tb.sv */
// Self-checking bench of the lockstep self-test block.
// Assumes the core pair model and the bound port checker.
`timescale 1ns/1ns
module tb;
   import lockstep_pkg::*;
   logic clock, rst, flip, pass, test_pass, cpu_reset, compare_error, irq, err;
   logic core_clock_enable, core_isolate;
   logic [2:0] ev; // Reset cause events.
   logic [31:0] system_in, core_a_in, core_b_in, core_a_out, core_b_out, system_out, q;
   logic [4:0] first_int;
   apb_request_type req;
   apb_answer_type ans;
   builtin_test_type test_engine;
   int bad_count = 0, checks_done = 0, steps, cyc, last, r;
   cpu_lockstep_self_test cpu_lockstep_self_test_inst (.clock, .rst, .apb_in(req),
      .apb_out(ans), .system_in, .core_a_in, .core_b_in, .core_a_out, .core_b_out,
      .system_out, .core_clock_enable, .core_isolate, .test_engine, .test_pass,
      .software_reset_event(ev[0]), .external_reset_event(ev[1]),
      .watchdog_reset_event(ev[2]), .cpu_reset, .compare_error, .irq);
   core_pair_model core_pair_model_inst (.clock, .core_a_in, .core_b_in, .flip, .pass,
      .core_a_out, .core_b_out, .test_pass);
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [31:0] seen, exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic wr, input logic [31:0] a, d);
      @(posedge clock);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clock);
      req.penable <= 1'b1;
      do @(posedge clock); while (ans.pready !== 1'b1);
      q = ans.prdata;
      err = ans.pslverr;
      req <= '0;
   endtask : apb
   // One run: step count, step spacing, start interval, status and reset cause.
   task automatic run(input logic [31:0] cfg, input logic ok, input int n,
                      input logic [4:0] start, input logic [31:0] st, m);
      steps = 0;
      pass <= ok;
      apb(1, ADDR_CONFIG, cfg);
      apb(1, ADDR_CONTROL, 32'h1);
      while (cpu_reset !== 1'b1) begin
         @(posedge clock);
         cyc++;
         if (test_engine.step === 1'b1) begin
            if (steps == 0) first_int = test_engine.interval;
            if (steps == 0) cyc = 0;
            last = cyc;
            steps++;
         end
      end
      while (cpu_reset === 1'b1) @(posedge clock);
      if (n > 0) chk(steps, n, "steps");
      if (n > 0) chk(last, (n - 1) * r, "span");
      chk(first_int, start, "start interval");
      apb(0, ADDR_RUN_STATUS, 0);
      chk(q & m, st, "run status");
      apb(0, ADDR_IRQ_STATUS, 0);
      chk(q[2:0], {st[2:1], 1'b1}, "events");
      chk(irq, 1, "irq");
      apb(0, ADDR_EXCEPTION, 0);
      chk(q[5], 1, "self-test cause");
      apb(1, ADDR_EXCEPTION, 32'h20);
      apb(1, ADDR_IRQ_STATUS, 32'h7);
      repeat (2) @(posedge clock);
      chk(irq, 0, "irq cleared");
   endtask : run
   task automatic report_and_stop;
      $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   // Random data keeps flowing into the cores, so the compare sees real traffic.
   always @(posedge clock) system_in <= $urandom;
   initial begin
      // Longest run is two intervals at eight cycles a step, far inside this span.
      #800_000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      void'($urandom(9902));
      rst = 1'b1;
      flip = 1'b0;
      pass = 1'b1;
      ev = 3'h0;
      req = '0;
      repeat (3) @(posedge clock);
      rst <= 0;
      apb(0, ADDR_TIMEOUT, 0);
      chk(q, TIMEOUT_RESET, "timeout reset");
      apb(0, 32'h0FFF_E120, 0);
      chk(q, 32'h0, "unmapped data");
      chk(err, 1'b1, "unmapped error");
      r = $urandom_range(7);
      apb(1, ADDR_CLOCK_DIVIDER, r);
      r = (r < 2) ? 3 : r + 1;
      apb(1, ADDR_IRQ_MASK, 32'hF);
      run(32'h101, 1, 1365, 0, 32'h0001_0000, 32'h001F_1FFF);
      run(32'h002, 1, 2730, 1, 32'h0003_0000, 32'h001F_1FFF);
      run(32'h001, 0, 1365, 3, 32'h0302, 32'h1FFF);
      apb(1, ADDR_TIMEOUT, 300);
      run(32'h100, 1, -1, 0, 32'h0004, 32'h7);
      chk(compare_error, 0, "no false mismatch");
      flip <= 1;
      @(posedge clock);
      flip <= 0;
      repeat (6) @(posedge clock);
      chk({compare_error, irq}, 2'b11, "mismatch");
      apb(1, ADDR_IRQ_STATUS, 32'h8);
      repeat (2) @(posedge clock);
      chk(compare_error, 0, "mismatch cleared");
      for (int i = 0; i < 3; i++) begin
         ev <= 3'h1 << i;
         @(posedge clock);
         ev <= 0;
         apb(0, ADDR_EXCEPTION, 0);
         chk(q & 32'h2038, i == 2 ? 32'h2000 : 32'h10 >> i, "reset cause");
         apb(1, ADDR_EXCEPTION, q);
      end
      report_and_stop();
   end
endmodule : tb
